// file: serial_autobaud_detector.sv
`timescale 1ns/1ps
module serial_autobaud_detector #(
   parameter int unsigned SAMPLE_DIV = autobaud_pkg::SAMPLE_DIV
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic rx_pin_i,
   input wire logic ctrl_req_i,
   input wire logic [autobaud_pkg::SUBFN_W-1:0] ctrl_subfn_i,
   input wire logic [autobaud_pkg::CFG_W-1:0] serial_cfg_i,
   input wire logic [autobaud_pkg::RATE_W-1:0] rate_code_i,
   output logic detect_active_o,
   output logic tx_enable_o,
   output logic status_irq_enable_o,
   output logic [autobaud_pkg::CFG_W-1:0] serial_cfg_o,
   output logic [autobaud_pkg::RATE_W-1:0] rate_gen_code_o,
   output logic rate_load_o,
   output logic done_o,
   output logic [autobaud_pkg::RATE_W-1:0] found_rate_o,
   output logic eighth_bit_o
);
   autobaud_pkg::detect_state_e state_q;
   logic hunt_q;
   logic sync_pulse;
   logic char_valid;
   logic [autobaud_pkg::CHAR_W-1:0] char_in;
   logic [autobaud_pkg::CHAR_W-1:0] char_q;
   logic busy_q;
   logic [2:0] bit_q;
   logic [2:0] run_q;
   logic [autobaud_pkg::RUN_W-1:0] cnt_q [autobaud_pkg::RUNS];
   logic [autobaud_pkg::RUN_W-1:0] cnt_next;
   logic [autobaud_pkg::RATE_W-1:0] addr_q;
   logic [autobaud_pkg::RATE_W-1:0] cmp_idx_q;
   logic cmp_valid_q;
   autobaud_pkg::rate_entry_s entry;
   logic [autobaud_pkg::CFG_W-1:0] saved_cfg_q;
   logic [autobaud_pkg::RATE_W-1:0] saved_rate_q;
   logic cur_bit;
   logic base_ok;
   logic short_ok;
   logic long_ok;
   logic req_enable;
   logic req_disable;
   logic overrun;
   logic timeout;
   logic run_done;
   logic matched;
   logic no_match;

   function automatic logic near(input logic [autobaud_pkg::RUN_W-1:0] meas,
                                 input logic [autobaud_pkg::CNT_W-1:0] ref_cnt,
                                 input logic [autobaud_pkg::TOL_W-1:0] tol);
      logic [autobaud_pkg::RUN_W:0] lo;
      logic [autobaud_pkg::RUN_W:0] hi;
      logic [autobaud_pkg::RUN_W:0] m;
      lo = {6'h0, ref_cnt};
      hi = {6'h0, ref_cnt} + {14'h0, tol};
      m = {1'b0, meas};
      near = (m + {14'h0, tol} >= lo) && (m <= hi);
   endfunction

   line_sampler #(.SAMPLE_DIV(SAMPLE_DIV)) sampler (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .rx_pin_i(rx_pin_i),
      .hunt_i(hunt_q),
      .sync_o(sync_pulse),
      .char_valid_o(char_valid),
      .char_o(char_in)
   );

   rate_table table_rom (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .addr_i(addr_q),
      .entry_o(entry)
   );

   assign req_enable = ctrl_req_i && ctrl_subfn_i == autobaud_pkg::SUBFN_ENABLE;
   assign req_disable = ctrl_req_i && ctrl_subfn_i == autobaud_pkg::SUBFN_DISABLE;
   // Processing a character takes eight cycles; a new one meanwhile is an overrun
   assign overrun = state_q == autobaud_pkg::ST_MEASURE && char_valid && busy_q;
   assign cur_bit = char_q[bit_q];
   assign cnt_next = cnt_q[run_q] + 1'b1;
   // A level matching the run's polarity extends it; runs alternate 0,1,0,1,0
   assign timeout = busy_q && cur_bit == run_q[0] && cnt_next[autobaud_pkg::RUN_W-1]; // [R19]
   assign run_done = busy_q && cur_bit != run_q[0] && run_q == autobaud_pkg::LAST_RUN; // [R4]

   always_comb begin
      base_ok = near(cnt_q[0], entry.c1, entry.tol) // [R5] [R7] [R8] [R9] [R10]
             && near(cnt_q[1], entry.c2, entry.tol)
             && near(cnt_q[2], entry.c3, entry.tol)
             && near(cnt_q[3], entry.c4, entry.tol);
      short_ok = near(cnt_q[4], entry.c5_short, entry.tol); // [R11]
      long_ok = near(cnt_q[4], entry.c5_long, entry.tol); // [R11]
   end
   assign matched = cmp_valid_q && base_ok && (short_ok || long_ok);
   assign no_match = cmp_valid_q && !matched && cmp_idx_q == autobaud_pkg::RATE_LAST; // [R17]

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= autobaud_pkg::ST_IDLE;
         hunt_q <= 1'b0;
      end else begin
         hunt_q <= 1'b0;
         if (req_disable && state_q != autobaud_pkg::ST_IDLE) begin
            state_q <= autobaud_pkg::ST_IDLE; // [R15]
         end else begin
            unique case (state_q)
               autobaud_pkg::ST_IDLE: begin
                  if (req_enable) begin
                     state_q <= autobaud_pkg::ST_HUNT; // [R13]
                     hunt_q <= 1'b1; // [R16]
                  end
               end
               autobaud_pkg::ST_HUNT: begin
                  if (sync_pulse) begin
                     state_q <= autobaud_pkg::ST_MEASURE; // [R2]
                  end
               end
               autobaud_pkg::ST_MEASURE: begin
                  if (overrun || timeout) begin
                     state_q <= autobaud_pkg::ST_HUNT; // [R17] [R19]
                     hunt_q <= 1'b1;
                  end else if (run_done) begin
                     state_q <= autobaud_pkg::ST_MATCH;
                  end
               end
               autobaud_pkg::ST_MATCH: begin
                  if (matched) begin
                     state_q <= autobaud_pkg::ST_IDLE; // [R15]
                  end else if (no_match) begin
                     state_q <= autobaud_pkg::ST_HUNT; // [R17]
                     hunt_q <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Run measurement, one sample bit per cycle; counts stay frozen through the table walk
   always_ff @(posedge clk_i) begin
      if (reset_i || state_q == autobaud_pkg::ST_IDLE
          || state_q == autobaud_pkg::ST_HUNT) begin
         busy_q <= 1'b0;
         bit_q <= autobaud_pkg::LAST_BIT;
         char_q <= '0;
         run_q <= '0;
         for (int i = 0; i < autobaud_pkg::RUNS; i++) begin
            cnt_q[i] <= '0;
         end
      end else if (state_q == autobaud_pkg::ST_MATCH) begin
         busy_q <= 1'b0;
      end else begin
         if (char_valid && !busy_q) begin
            char_q <= char_in; // [R3]
            busy_q <= 1'b1;
            bit_q <= autobaud_pkg::LAST_BIT;
         end else if (busy_q) begin
            bit_q <= bit_q - 1'b1;
            if (bit_q == '0) begin
               busy_q <= 1'b0;
            end
            if (cur_bit == run_q[0]) begin
               cnt_q[run_q] <= cnt_next; // [R4]
            end else if (run_q != autobaud_pkg::LAST_RUN) begin
               run_q <= run_q + 1'b1; // [R4]
               cnt_q[run_q + 1'b1] <= 16'h0001;
            end
         end
      end
   end

   // Table walk; read data lags the address by one cycle
   always_ff @(posedge clk_i) begin
      if (reset_i || state_q != autobaud_pkg::ST_MATCH) begin
         addr_q <= '0;
         cmp_idx_q <= '0;
         cmp_valid_q <= 1'b0;
      end else begin
         addr_q <= addr_q + 1'b1;
         cmp_idx_q <= addr_q;
         cmp_valid_q <= !matched && !no_match;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         saved_cfg_q <= '0;
         saved_rate_q <= '0;
         detect_active_o <= 1'b0;
         tx_enable_o <= 1'b1;
         status_irq_enable_o <= 1'b1;
         serial_cfg_o <= '0;
         rate_gen_code_o <= '0;
         rate_load_o <= 1'b0;
         done_o <= 1'b0;
         found_rate_o <= '0;
         eighth_bit_o <= 1'b0;
      end else begin
         rate_load_o <= 1'b0;
         done_o <= 1'b0;
         if (state_q == autobaud_pkg::ST_IDLE && req_enable) begin
            saved_cfg_q <= serial_cfg_i;
            saved_rate_q <= rate_code_i;
            detect_active_o <= 1'b1; // [R13]
            tx_enable_o <= 1'b0; // [R14]
            status_irq_enable_o <= 1'b0; // [R14]
            serial_cfg_o <= autobaud_pkg::HUNT_CFG; // [R1]
            rate_gen_code_o <= autobaud_pkg::RATE_SAMPLE;
            rate_load_o <= 1'b1;
         end else if (state_q != autobaud_pkg::ST_IDLE && req_disable) begin
            detect_active_o <= 1'b0; // [R15]
            tx_enable_o <= 1'b1;
            status_irq_enable_o <= 1'b1;
            serial_cfg_o <= saved_cfg_q;
            rate_gen_code_o <= saved_rate_q;
            rate_load_o <= 1'b1;
         end else if (state_q == autobaud_pkg::ST_MATCH && matched) begin
            detect_active_o <= 1'b0; // [R15]
            tx_enable_o <= 1'b1;
            status_irq_enable_o <= 1'b1;
            serial_cfg_o <= saved_cfg_q;
            rate_gen_code_o <= cmp_idx_q; // [R18]
            rate_load_o <= 1'b1;
            done_o <= 1'b1; // [R20]
            found_rate_o <= cmp_idx_q;
            eighth_bit_o <= short_ok; // [R12]
         end
      end
   end

   sequence enable_seen;
      state_q == autobaud_pkg::ST_IDLE && req_enable;
   endsequence
   sequence detect_entered;
      detect_active_o && !tx_enable_o && !status_irq_enable_o && rate_load_o;
   endsequence
   sequence match_taken;
      state_q == autobaud_pkg::ST_MATCH && matched && !req_disable;
   endsequence
   sequence success_shown;
      done_o && rate_load_o && tx_enable_o && status_irq_enable_o
      && serial_cfg_o == saved_cfg_q;
   endsequence

   enable_enters_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
      enable_seen |=> detect_entered ##0 state_q == autobaud_pkg::ST_HUNT)
      else $error("enable did not enter detection");
   hunt_on_enable_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R16]
      enable_seen |=> hunt_q)
      else $error("enable did not request hunt");
   tx_quiet_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
      detect_active_o |-> !tx_enable_o && !status_irq_enable_o)
      else $error("transmitter live during detection");
   disable_restores_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R15]
      state_q != autobaud_pkg::ST_IDLE && req_disable |=>
      !detect_active_o && rate_load_o && serial_cfg_o == saved_cfg_q
      && rate_gen_code_o == saved_rate_q)
      else $error("disable did not restore settings");
   done_programs_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R18]
      done_o |-> rate_load_o && rate_gen_code_o == found_rate_o && !detect_active_o)
      else $error("success without rate programming");
   done_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R20]
      done_o |=> !done_o)
      else $error("completion strobe longer than one cycle");
   miss_hunts_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R17]
      ((state_q == autobaud_pkg::ST_MATCH && no_match) || overrun) && !req_disable
      |=> hunt_q && state_q == autobaud_pkg::ST_HUNT)
      else $error("failed match did not return to hunt");
   match_bounded_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
      $rose(state_q == autobaud_pkg::ST_MATCH) |-> ##[1:18] state_q != autobaud_pkg::ST_MATCH)
      else $error("table walk overran");
   timeout_hunts_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R19]
      timeout && !req_disable |=> state_q == autobaud_pkg::ST_HUNT && hunt_q)
      else $error("negative count did not time out");
   eighth_bit_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
      state_q == autobaud_pkg::ST_MATCH && matched && !req_disable |=> eighth_bit_o == $past(short_ok))
      else $error("eighth bit wrong");
   success_restores_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R15]
      match_taken |=> success_shown ##0 state_q == autobaud_pkg::ST_IDLE)
      else $error("success did not restore settings");
   // The walk reads the counts for up to sixteen cycles, so they must not move meanwhile
   counts_held_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
      state_q == autobaud_pkg::ST_MATCH && $past(state_q) == autobaud_pkg::ST_MATCH
      |-> $stable(cnt_q[0]) && $stable(cnt_q[3]) && $stable(cnt_q[4]))
      else $error("run counts moved during table walk");
   hunt_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R16]
      hunt_q |=> !hunt_q)
      else $error("hunt request longer than one cycle");
   load_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R18]
      rate_load_o && !ctrl_req_i |=> !rate_load_o)
      else $error("rate load longer than one cycle");
   busy_refuses_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
      (state_q == autobaud_pkg::ST_HUNT || state_q == autobaud_pkg::ST_MEASURE)
      && !req_disable |=> !rate_load_o && detect_active_o)
      else $error("request taken while detecting");
   active_tracks_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
      detect_active_o == (state_q != autobaud_pkg::ST_IDLE))
      else $error("detect flag out of step with state");
endmodule

// file: autobaud_pkg.sv
// How it works
// [R1] Sample line at 19200, eight samples per character
// [R2] Hunt for pattern 11111110B before measuring
// [R3] Hand each assembled character straight to measurement
// [R4] Count five runs: zeros, ones, zeros, ones, zeros
// [R5] Compare run counts with per-rate table
// [R6] Odd rates hold rounded integer counts
// [R7] Rates 50 to 600 accept plus/minus 5
// [R8] Rates 900 to 1800 accept plus/minus 2
// [R9] Rates 2400 to 9600 accept plus/minus 1
// [R10] Rate 19200 needs exact counts
// [R11] Fifth run matches short or long alternative
// [R12] Eighth bit one for short, zero for long
// [R13] Subfunction 6 switches port into rate detection
// [R14] Detection disables transmitter and status interrupts
// [R15] Success or subfunction 7 restores normal settings
// [R16] Enabling detection puts sampler into hunt
// [R17] No match or overrun returns to hunt
// [R18] Reprogram rate generator with detected rate
// [R19] 16-bit run counters; negative count means time-out
// [R20] Success gives rate, eighth bit, one-cycle strobe
package autobaud_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SAMPLE_BPS = 19200;
   localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_BPS;
   localparam int DIV_W = 13;
   localparam int CHAR_W = 8;
   localparam int RUN_W = 16;
   localparam int RUNS = 5;
   localparam int CNT_W = 11;
   localparam int RATE_W = 4;
   localparam int TOL_W = 3;
   localparam int SUBFN_W = 4;
   localparam int CFG_W = 8;
   localparam logic [CHAR_W-1:0] SYNC_PATTERN = 8'hFE;
   localparam logic [SUBFN_W-1:0] SUBFN_ENABLE = 4'h6;
   localparam logic [SUBFN_W-1:0] SUBFN_DISABLE = 4'h7;
   localparam logic [RATE_W-1:0] RATE_SAMPLE = 4'h0;
   localparam logic [RATE_W-1:0] RATE_LAST = 4'hF;
   localparam logic [CFG_W-1:0] HUNT_CFG = 8'h81;
   localparam logic [2:0] LAST_RUN = 3'h4;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [TOL_W-1:0] TOL_EXACT = 3'h0;
   localparam logic [TOL_W-1:0] TOL_FINE = 3'h1;
   localparam logic [TOL_W-1:0] TOL_MID = 3'h2;
   localparam logic [TOL_W-1:0] TOL_WIDE = 3'h5;
   typedef struct packed {
      logic [CNT_W-1:0] c1;
      logic [CNT_W-1:0] c2;
      logic [CNT_W-1:0] c3;
      logic [CNT_W-1:0] c4;
      logic [CNT_W-1:0] c5_short;
      logic [CNT_W-1:0] c5_long;
      logic [TOL_W-1:0] tol;
   } rate_entry_s;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HUNT = 2'b01,
      ST_MEASURE = 2'b11,
      ST_MATCH = 2'b10
   } detect_state_e;
endpackage

// file: rate_table.sv
`timescale 1ns/1ps
module rate_table (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [autobaud_pkg::RATE_W-1:0] addr_i,
   output autobaud_pkg::rate_entry_s entry_o
);
   function automatic autobaud_pkg::rate_entry_s mk(
      input logic [10:0] a, input logic [10:0] b, input logic [10:0] c,
      input logic [10:0] d, input logic [10:0] e, input logic [10:0] f,
      input logic [2:0] t);
      mk = '{c1: a, c2: b, c3: c, c4: d, c5_short: e, c5_long: f, tol: t};
   endfunction

   // Fastest rate first so overlapping wide bands never shadow a fast match
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         entry_o <= '0;
      end else begin
         unique case (addr_i)
            4'h0: entry_o <= mk(11'h0, 11'h1, 11'h1, 11'h2, 11'h3, 11'h4,
                                autobaud_pkg::TOL_EXACT); // [R10]
            4'h1: entry_o <= mk(11'h1, 11'h2, 11'h2, 11'h4, 11'h6, 11'h8,
                                autobaud_pkg::TOL_FINE); // [R5] [R9]
            4'h2: entry_o <= mk(11'h2, 11'h3, 11'h3, 11'h6, 11'h9, 11'hC,
                                autobaud_pkg::TOL_FINE); // [R6] [R9]
            4'h3: entry_o <= mk(11'h3, 11'h4, 11'h4, 11'h8, 11'hC, 11'h10,
                                autobaud_pkg::TOL_FINE); // [R9]
            4'h4: entry_o <= mk(11'h4, 11'h5, 11'h5, 11'hA, 11'hF, 11'h14,
                                autobaud_pkg::TOL_FINE); // [R6] [R9]
            4'h5: entry_o <= mk(11'h7, 11'h8, 11'h8, 11'h10, 11'h18, 11'h20,
                                autobaud_pkg::TOL_FINE); // [R9]
            4'h6: entry_o <= mk(11'hA, 11'hB, 11'hB, 11'h16, 11'h21, 11'h2C,
                                autobaud_pkg::TOL_MID); // [R6] [R8]
            4'h7: entry_o <= mk(11'hF, 11'h10, 11'h10, 11'h20, 11'h30, 11'h40,
                                autobaud_pkg::TOL_MID); // [R8]
            4'h8: entry_o <= mk(11'h14, 11'h15, 11'h15, 11'h2A, 11'h3F, 11'h54,
                                autobaud_pkg::TOL_MID); // [R6] [R8]
            4'h9: entry_o <= mk(11'h1F, 11'h20, 11'h20, 11'h40, 11'h60, 11'h6C,
                                autobaud_pkg::TOL_WIDE); // [R7]
            4'hA: entry_o <= mk(11'h3F, 11'h40, 11'h40, 11'h80, 11'hC0, 11'h100,
                                autobaud_pkg::TOL_WIDE); // [R7]
            4'hB: entry_o <= mk(11'h7F, 11'h80, 11'h80, 11'h100, 11'h180, 11'h200,
                                autobaud_pkg::TOL_WIDE); // [R7]
            4'hC: entry_o <= mk(11'h8E, 11'h8F, 11'h8F, 11'h11E, 11'h1AD, 11'h23C,
                                autobaud_pkg::TOL_WIDE); // [R6] [R7]
            4'hD: entry_o <= mk(11'hAE, 11'hAF, 11'hAF, 11'h15E, 11'h20D, 11'h2BC,
                                autobaud_pkg::TOL_WIDE); // [R6] [R7]
            4'hE: entry_o <= mk(11'hFF, 11'h100, 11'h100, 11'h200, 11'h300, 11'h400,
                                autobaud_pkg::TOL_WIDE); // [R7]
            4'hF: entry_o <= mk(11'h17F, 11'h180, 11'h180, 11'h300, 11'h480, 11'h602,
                                autobaud_pkg::TOL_WIDE); // [R7]
         endcase
      end
   end
endmodule

// file: line_sampler.sv
`timescale 1ns/1ps
module line_sampler #(
   parameter int unsigned SAMPLE_DIV = autobaud_pkg::SAMPLE_DIV
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic rx_pin_i,
   input wire logic hunt_i,
   output logic sync_o,
   output logic char_valid_o,
   output logic [autobaud_pkg::CHAR_W-1:0] char_o
);
   logic [2:0] sync_q;
   logic level_q;
   logic [autobaud_pkg::DIV_W-1:0] div_q;
   logic tick;
   logic synced_q;
   logic [2:0] bit_q;
   logic [autobaud_pkg::CHAR_W-1:0] shift_q;
   logic [autobaud_pkg::CHAR_W-1:0] shift_d;
   localparam logic [autobaud_pkg::DIV_W-1:0] DIV_LAST = (autobaud_pkg::DIV_W)'(SAMPLE_DIV - 1);

   // Line is asynchronous; a change counts only once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync_q <= 3'h7;
         level_q <= 1'b1;
      end else begin
         sync_q <= {sync_q[1:0], rx_pin_i};
         if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
         end
      end
   end

   // One sample per bit time of the 19200 sample clock
   always_ff @(posedge clk_i) begin
      if (reset_i || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1; // [R1]
      end
   end
   assign tick = (div_q == DIV_LAST);
   assign shift_d = {shift_q[autobaud_pkg::CHAR_W-2:0], level_q};

   always_ff @(posedge clk_i) begin
      if (reset_i || hunt_i) begin
         synced_q <= 1'b0;
         shift_q <= '0;
         bit_q <= '0;
         sync_o <= 1'b0;
         char_valid_o <= 1'b0;
         char_o <= '0;
      end else begin
         sync_o <= 1'b0;
         char_valid_o <= 1'b0;
         if (tick) begin
            shift_q <= shift_d;
            if (!synced_q) begin
               if (shift_d == autobaud_pkg::SYNC_PATTERN) begin // [R2]
                  synced_q <= 1'b1;
                  sync_o <= 1'b1;
                  bit_q <= '0;
               end
            end else begin
               bit_q <= bit_q + 1'b1; // [R1]
               if (bit_q == autobaud_pkg::LAST_BIT) begin
                  char_valid_o <= 1'b1; // [R3]
                  char_o <= shift_d;
               end
            end
         end
      end
   end

   sync_pattern_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R2]
      sync_o |-> shift_q == autobaud_pkg::SYNC_PATTERN && synced_q)
      else $error("sync without hunt pattern");
   char_spacing_a: assert property (@(posedge clk_i) disable iff (reset_i || hunt_i) // [R1]
      char_valid_o |=> !char_valid_o [*8])
      else $error("characters closer than eight samples");
endmodule

// file: cr_terminal.sv
`timescale 1ns/1ps
module cr_terminal #(
   parameter int unsigned SAMPLE_DIV = 8
) (
   input wire logic clk_i,
   input wire logic send_i,
   input wire logic [79:0] runs_i,
   output logic rx_o,
   output logic busy_o
);
   initial begin
      rx_o = 1'b1;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (send_i) begin
            busy_o <= 1'b1;
            // Long idle ones ahead of the start bit give the sampler its hunt pattern
            repeat (16 * SAMPLE_DIV) @(negedge clk_i);
            for (int k = 0; k < 5; k++) begin
               rx_o <= (k % 2 == 1);
               repeat (runs_i[16*k +: 16] * SAMPLE_DIV) @(negedge clk_i);
            end
            rx_o <= 1'b1;
            busy_o <= 1'b0;
         end
      end
   end
endmodule

// file: serial_autobaud_detector_bench.sv
`timescale 1ns/1ps
module serial_autobaud_detector_bench;
   localparam int unsigned DIV = 8;
   // Rate code, bit length in samples, count offset, long fifth run, match expected
   localparam int CODE [14] = '{0, 0, 1, 1, 3, 5, 5, 7, 7, 9, 9, 10, 11, 14};
   localparam int NBIT [14] = '{1, 1, 2, 2, 4, 8, 8, 16, 16, 32, 32, 64, 128, 256};
   localparam int OFFS [14] = '{0, 0, 1, -1, 0, 1, 2, 2, -3, -5, 6, 0, 0, 0};
   localparam bit LONG [14] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 0, 0, 1, 0, 1};
   localparam bit HIT [14] = '{1, 1, 1, 1, 1, 1, 0, 1, 0, 1, 0, 1, 1, 1};
   logic clk_i, reset_i, rx_pin_i, ctrl_req_i, send, busy, loaded, active, got;
   logic [3:0] ctrl_subfn_i, rate_code_i, rate_gen_code_o, found_rate_o, rate_sv;
   logic [7:0] serial_cfg_i, serial_cfg_o, cfg_sv;
   logic detect_active_o, tx_enable_o, status_irq_enable_o, rate_load_o, done_o, eighth_bit_o;
   logic [79:0] runs;
   logic [31:0] seed;
   int errors, comparisons;

   serial_autobaud_detector #(.SAMPLE_DIV(DIV)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
      .rx_pin_i(rx_pin_i), .ctrl_req_i(ctrl_req_i), .ctrl_subfn_i(ctrl_subfn_i),
      .serial_cfg_i(serial_cfg_i), .rate_code_i(rate_code_i),
      .detect_active_o(detect_active_o), .tx_enable_o(tx_enable_o),
      .status_irq_enable_o(status_irq_enable_o), .serial_cfg_o(serial_cfg_o),
      .rate_gen_code_o(rate_gen_code_o), .rate_load_o(rate_load_o), .done_o(done_o),
      .found_rate_o(found_rate_o), .eighth_bit_o(eighth_bit_o));
   cr_terminal #(.SAMPLE_DIV(DIV)) i_term (.clk_i(clk_i), .send_i(send), .runs_i(runs),
      .rx_o(rx_pin_i), .busy_o(busy));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // The sync zero belongs to the first run but is not counted by the detector
   function automatic logic [79:0] runs_for(input int n, input int d, input bit lng);
      return {16'(n * (lng ? 4 : 3) + d), 16'(2 * n + d), 16'(n + d), 16'(n + d), 16'(n + d)};
   endfunction

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic request(input logic [3:0] fn);
      ctrl_subfn_i = fn;
      ctrl_req_i = 1'b1;
      @(negedge clk_i);
      ctrl_req_i = 1'b0;
      loaded = 1'b0;
      repeat (2) begin
         if (rate_load_o === 1'b1) loaded = 1'b1;
         @(negedge clk_i);
      end
   endtask

   task automatic new_inputs();
      seed = lfsr(seed);
      serial_cfg_i = seed[7:0];
      rate_code_i = seed[11:8];
      if (active !== 1'b1) begin
         cfg_sv = seed[7:0];
         rate_sv = seed[11:8];
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #1_000_000;
      errors++;
      stop_test();
   end

   initial begin
      {ctrl_req_i, send, active} = 3'b000;
      {ctrl_subfn_i, serial_cfg_i, rate_code_i, runs, errors, comparisons} = '0;
      seed = 32'h1FD5;
      reset_i = 1'b1;
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      check("reset outputs", 16'h0003, {detect_active_o, tx_enable_o, status_irq_enable_o});
      check("reset codes", 16'h0000, {serial_cfg_o, rate_gen_code_o, found_rate_o});
      repeat (4) @(negedge clk_i);
      for (int i = 0; i < 14; i++) begin
         new_inputs();
         request(4'h6);
         check("enable load", !active, loaded);
         if (!active) begin
            check("hunt cfg", autobaud_pkg::HUNT_CFG, serial_cfg_o);
            check("sample rate", autobaud_pkg::RATE_SAMPLE, rate_gen_code_o);
         end
         active = 1'b1;
         check("detect on", 16'h0004, {detect_active_o, tx_enable_o, status_irq_enable_o});
         runs = runs_for(NBIT[i], OFFS[i], LONG[i]);
         send = 1'b1;
         @(negedge clk_i);
         send = 1'b0;
         @(negedge clk_i);
         while (busy === 1'b1) @(negedge clk_i);
         got = 1'b0;
         for (int w = 0; w < 200 && !got; w++) begin
            if (done_o === 1'b1) begin
               got = 1'b1;
               check("found rate", CODE[i], found_rate_o);
               check("eighth bit", !LONG[i], eighth_bit_o);
               check("rate reload", {4'(CODE[i]), 1'b1}, {rate_gen_code_o, rate_load_o});
               check("cfg back", cfg_sv, serial_cfg_o);
               check("normal", 16'h0003, {detect_active_o, tx_enable_o, status_irq_enable_o});
            end
            @(negedge clk_i);
         end
         check("match", HIT[i], got);
         if (got) begin
            check("strobe width", 16'h0000, done_o);
            active = 1'b0;
         end
      end
      new_inputs();
      request(4'h6);
      check("enable again", 16'h0001, loaded);
      active = 1'b1;
      new_inputs();
      request(4'h7);
      check("disable load", 16'h0001, loaded);
      check("disable cfg", cfg_sv, serial_cfg_o);
      check("disable rate", rate_sv, rate_gen_code_o);
      check("disable state", 16'h0003, {detect_active_o, tx_enable_o, status_irq_enable_o});
      active = 1'b0;
      for (int f = 0; f < 16; f++) begin
         if (f != 6) begin
            request(4'(f));
            check("refused code", 16'h0000, {loaded, detect_active_o});
         end
      end
      stop_test();
   end
endmodule
